// *** verification/sfac_host_model.sv ***
module sfac_host_model (
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out,
    input  wire logic so_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link clock rests low between frames; SI toggles when it means nothing
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end

    task automatic clk_bit(input logic b, output logic r);
        si_out = b;
        #62.5 sck_out = 1'b1;
        r = so_in;
        #62.5 sck_out = 1'b0;
    endtask

    task automatic frame(input logic [7:0] tx[$], input int nrd,
                         input int xb, output logic [7:0] rx[$]);
        logic       r;
        logic [7:0] v;
        rx = {};
        cs_n_out = 1'b0;
        foreach (tx[i]) for (int k = 7; k >= 0; k--) clk_bit(tx[i][k], r);
        for (int k = 0; k < xb; k++) clk_bit(~si_out, r);
        for (int j = 0; j < nrd; j++) begin
            for (int k = 7; k >= 0; k--) begin
                clk_bit(~si_out, r);
                v[k] = r;
            end
            rx.push_back(v);
        end
        #31 cs_n_out = 1'b1;
        si_out = ~si_out;
        #500;
    endtask
endmodule

// *** verification/tb_serial_flash_array_commands.sv ***
module tb_serial_flash_array_commands;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_in, reset_n_in, wp_n_in, cs_n, sck, si;
    logic       so_out, so_oe_n_out, busy_out, wel_out;
    logic       bpl, bph, protect_pin_enable_bit;
    logic [7:0] exp_q[$], got_q[$], rx[$], g, e;
    int         n_fail = 0, comparisons = 0, oe_cnt = 0;

    sfac_host_model host_u (
        .cs_n_out (cs_n),
        .sck_out  (sck),
        .si_out   (si),
        .so_in    (so_oe_n_out ? ~so_out : so_out)
    );

    // Long counts shortened; program kept long enough to probe while busy
    sfac_flash #(
        .PROG_CYCLES (32'd4000),
        .SECT_CYCLES (32'd64),
        .CHIP_CYCLES (32'd64)
    ) dut_u (
        .clk_in                     (clk_in),
        .reset_n_in                 (reset_n_in),
        .cs_n_in                    (cs_n),
        .sck_in                     (sck),
        .si_in                      (si),
        .wp_n_in                    (wp_n_in),
        .so_out                     (so_out),
        .so_oe_n_out                (so_oe_n_out),
        .busy_out                   (busy_out),
        .wel_out                    (wel_out),
        .block_protect_low_out      (bpl),
        .block_protect_high_out     (bph),
        .protect_pin_enable_bit_out (protect_pin_enable_bit)
    );

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    always @(posedge clk_in) if (so_oe_n_out === 1'b0) oe_cnt <= oe_cnt + 1;

    task automatic fail(input string m);
        n_fail++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic close_out();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Oldest note meets oldest result
    always @(negedge clk_in) begin
        if (got_q.size() > 0) begin
            g = got_q.pop_front();
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            comparisons++;
            if (g !== e) begin
                $display("[FAIL] %0t got %h expected %h", $time, g, e);
                n_fail++;
            end
        end
    end

    task automatic note(input logic [7:0] v);
        exp_q.push_back(v);
    endtask

    task automatic obs(input logic [7:0] v);
        got_q.push_back(v);
    endtask

    task automatic fr(input logic [7:0] tx[$], input int nrd = 0,
                      input int xb = 0);
        host_u.frame(tx, nrd, xb, rx);
        foreach (rx[i]) got_q.push_back(rx[i]);
    endtask

    task automatic set_write_latch_cmd();
        fr({8'h06});
    endtask

    task automatic wrsr(input logic [7:0] b);
        set_write_latch_cmd();
        fr({8'h01, b});
    endtask

    task automatic st(input logic [7:0] v);
        note(v);
        fr({8'h05}, 1);
    endtask

    task automatic prog(input logic [23:0] a, input logic [7:0] d[$],
                        input int xb = 0, input logic [7:0] op = 8'h02);
        fr({op, a[23:16], a[15:8], a[7:0], d}, 0, xb);
    endtask

    task automatic rd(input logic [23:0] a, input logic [7:0] v[$],
                      input logic [7:0] op = 8'h03);
        foreach (v[i]) note(v[i]);
        fr({op, a[23:16], a[15:8], a[7:0]}, v.size());
    endtask

    task automatic busy_is(input logic v);
        note({7'h0, v});
        obs({7'h0, busy_out});
    endtask

    // Bound covers a full sector walk
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < 40000) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 40000) begin
            fail("busy never cleared");
            close_out();
        end
    endtask

    initial begin
        logic [7:0] d[$];
        int         c;
        reset_n_in = 1'b0;
        wp_n_in = 1'b0;
        void'($urandom(76));
        repeat (10) @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (5) @(negedge clk_in);
        note(8'h00);
        obs({3'h0, protect_pin_enable_bit, busy_out, wel_out, bph, bpl});
        st(8'h00);
        d = {8'($urandom), 8'($urandom), 8'($urandom)};
        prog(24'h000040, d);
        busy_is(1'b0);
        rd(24'h000040, {8'hFF});
        set_write_latch_cmd();
        prog(24'h000050, {d[0]}, 3);
        busy_is(1'b0);
        rd(24'h000050, {8'hFF});
        set_write_latch_cmd();
        prog(24'hA000FE, d, 0, 8'h0A);
        busy_is(1'b1);
        st(8'hFF);
        c = oe_cnt;
        fr({8'h03, 8'h00, 8'h00, 8'h00}, 0, 8);
        note(8'h00);
        obs(8'(oe_cnt - c));
        wait_idle();
        st(8'h00);
        rd(24'h0000FD, {8'hFF, d[0], d[1], 8'hFF});
        rd(24'h01FFFF, {8'hFF, d[2], 8'hFF}, 8'h0B);
        // Fresh address per level so no byte is programmed twice
        for (int lv = 0; lv < 4; lv++) begin
            wrsr(8'(lv << 2));
            note(8'(lv));
            obs({6'h0, bph, bpl});
            set_write_latch_cmd();
            prog({8'h01, 8'(lv), 8'h00}, {d[lv % 3]});
            busy_is(lv < 2);
            wait_idle();
            rd({8'h01, 8'(lv), 8'h00}, {lv < 2 ? d[lv % 3] : 8'hFF});
        end
        set_write_latch_cmd();
        fr({8'h62});
        busy_is(1'b0);
        rd(24'h010100, {d[1]});
        wrsr(8'h04);
        set_write_latch_cmd();
        fr({8'h52, 8'h01, 8'hAB, 8'hCD});
        busy_is(1'b0);
        fr({8'h5A, 8'h00, 8'h01, 8'h23});
        busy_is(1'b1);
        wait_idle();
        note(8'h00);
        obs({7'h0, wel_out});
        rd(24'h0000FE, {8'hFF, 8'hFF});
        rd(24'h000000, {8'hFF});
        rd(24'h010100, {d[1]});
        wrsr(8'h80);
        wrsr(8'h00);
        note(8'h01);
        obs({7'h0, protect_pin_enable_bit});
        @(negedge clk_in);
        wp_n_in = 1'b1;
        wrsr(8'h00);
        note(8'h00);
        obs({7'h0, protect_pin_enable_bit});
        repeat (50) @(negedge clk_in);
        if (exp_q.size() != 0) fail("results missing");
        close_out();
    end
endmodule

// *** verilog/sfac_defines.svh ***
`ifndef SFAC_DEFINES_SVH
`define SFAC_DEFINES_SVH

// Clock rate and self-timed cycle lengths
`define SFAC_CLK_MHZ     250
`define SFAC_PROG_US     20
`define SFAC_SECT_MS     1000
`define SFAC_CHIP_MS     3500
`define SFAC_PROG_CYC    (`SFAC_PROG_US * `SFAC_CLK_MHZ)
`define SFAC_SECT_CYC    (`SFAC_SECT_MS * 1000 * `SFAC_CLK_MHZ)
`define SFAC_CHIP_CYC    (`SFAC_CHIP_MS * 1000 * `SFAC_CLK_MHZ)

// Opcodes, bit 3 is don't care
`define SFAC_OP_MASK     8'hF7
`define SFAC_OP_SET_WEL  8'h06
`define SFAC_OP_CLR_WEL  8'h04
`define SFAC_OP_STAT_RD  8'h05
`define SFAC_OP_STAT_WR  8'h01
`define SFAC_OP_READ     8'h03
`define SFAC_OP_PROG     8'h02
`define SFAC_OP_SECT_ER  8'h52
`define SFAC_OP_CHIP_ER  8'h62

// Array geometry
`define SFAC_MEM_BYTES   131072
`define SFAC_ADDR_TOP    17'h1FFFF
`define SFAC_ADDR_ZERO   17'h00000
`define SFAC_PAGE_FIRST  8'h00
`define SFAC_PAGE_LAST   8'hFF
`define SFAC_SECT_FIRST  15'h0000
`define SFAC_SECT_LAST   15'h7FFF
`define SFAC_ERASED      8'hFF

// Status byte
`define SFAC_STAT_BUSY   8'hFF
`define SFAC_ST_PROTECT_PIN_ENABLE_BIT     7
`define SFAC_ST_BPH      3
`define SFAC_ST_BPL      2
`define SFAC_BP_ALL      2'h3

// Pin idle levels: cs_n, sck, si, wp_n
`define SFAC_PIN_IDLE    4'h9

// Serial framing
`define SFAC_BIT_LAST    3'h7
`define SFAC_BIT_FIRST   3'h0
`define SFAC_ADDR_LAST   5'h17

`endif

// *** verilog/sfac_flash.sv ***
`include "sfac_defines.svh"

module sfac_flash #(
    parameter logic [31:0] PROG_CYCLES = `SFAC_PROG_CYC,
    parameter logic [31:0] SECT_CYCLES = `SFAC_SECT_CYC,
    parameter logic [31:0] CHIP_CYCLES = `SFAC_CHIP_CYC
) (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic cs_n_in,
    input  wire logic sck_in,
    input  wire logic si_in,
    input  wire logic wp_n_in,
    output logic      so_out,
    output logic      so_oe_n_out,
    output logic      busy_out,
    output logic      wel_out,
    output logic      block_protect_low_out,
    output logic      block_protect_high_out,
    output logic      protect_pin_enable_bit_out
);
    function automatic logic locked(input logic [1:0] sec,
                                    input logic [1:0] bp);
        locked = (bp == `SFAC_BP_ALL) || (bp == 2'h2 && sec[1])
              || (bp == 2'h1 && sec == 2'h3);
    endfunction

    function automatic logic op_is(input logic [7:0] op,
                                   input logic [7:0] code);
        op_is = (op & `SFAC_OP_MASK) == code;
    endfunction

    // Pin synchronisers, second stage only feeds logic
    logic [3:0] pin_m_q, pin_s_q;
    logic       cs_p_q, sck_p_q;
    logic       cs_s_q, sck_s_q, si_s_q, wp_s_q;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_m_q <= `SFAC_PIN_IDLE;
            pin_s_q <= `SFAC_PIN_IDLE;
            cs_p_q  <= 1'b1;
            sck_p_q <= 1'b0;
        end else begin
            pin_m_q <= {cs_n_in, sck_in, si_in, wp_n_in};
            pin_s_q <= pin_m_q;
            cs_p_q  <= cs_s_q;
            sck_p_q <= sck_s_q;
        end
    end
    assign {cs_s_q, sck_s_q, si_s_q, wp_s_q} = pin_s_q;

    logic cs_rise, sck_rise, sck_fall, hw_prot;
    assign cs_rise  = cs_s_q && !cs_p_q;
    assign sck_rise = sck_s_q && !sck_p_q;
    assign sck_fall = !sck_s_q && sck_p_q;
    assign hw_prot  = !wp_s_q && protect_pin_enable_bit_out;

    sfac_pkg::sfac_state_e state_q, state_d;
    sfac_pkg::sfac_kind_e  kind_q, kind_d;
    logic [4:0]   cnt_q, cnt_d;
    logic [7:0]   sh_q, sh_d, op_q, op_d, out_q, out_d, byte_in, stat_byte;
    logic [16:0]  addr_q, addr_d, walk_q, walk_d, wend_q, wend_d;
    logic [31:0]  timer_q, timer_d;
    logic [255:0] pmask_q, pmask_d;
    logic so_d, oe_n_d, busy_d, wel_d, bpl_d, bph_d, protect_pin_enable_bit_d, wdone_q, wdone_d;
    logic pbuf_we, mem_we;
    logic [7:0] mem_rd_q, mem_wdata;
    logic [7:0] mem [0:`SFAC_MEM_BYTES-1];
    logic [7:0] pbuf [0:255];
    logic [1:0] bp;

    assign byte_in   = {sh_q[6:0], si_s_q};
    assign bp        = {block_protect_high_out, block_protect_low_out};
    assign stat_byte = busy_out ? `SFAC_STAT_BUSY
                     : {protect_pin_enable_bit_out, 3'h0, bp, wel_out, 1'b0};

    always_comb begin
        state_d = state_q;
        kind_d  = kind_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        op_d    = op_q;
        out_d   = out_q;
        addr_d  = addr_q;
        walk_d  = walk_q;
        wend_d  = wend_q;
        timer_d = timer_q;
        pmask_d = pmask_q;
        so_d    = so_out;
        oe_n_d  = so_oe_n_out;
        busy_d  = busy_out;
        wel_d   = wel_out;
        bpl_d   = block_protect_low_out;
        bph_d   = block_protect_high_out;
        protect_pin_enable_bit_d  = protect_pin_enable_bit_out;
        wdone_d = wdone_q;
        pbuf_we = 1'b0;
        // Self-timed cycle: array walk plus a minimum duration
        if (busy_out) begin
            if (timer_q != 32'h0)
                timer_d = timer_q - 32'h1;
            if (!wdone_q) begin
                walk_d = walk_q + 17'h1;
                if (walk_q == wend_q)
                    wdone_d = 1'b1;
            end
            if (timer_q == 32'h0 && wdone_q) begin
                busy_d = 1'b0;
                wel_d  = 1'b0;
            end
        end
        if (cs_s_q) begin
            state_d = sfac_pkg::ST_CMD;
            cnt_d   = 5'h0;
            oe_n_d  = 1'b1;
            if (cs_rise && state_q == sfac_pkg::ST_TAIL) begin
                if (op_is(op_q, `SFAC_OP_SET_WEL))
                    wel_d = 1'b1;
                else if (op_is(op_q, `SFAC_OP_CLR_WEL))
                    wel_d = 1'b0;
                else if (op_is(op_q, `SFAC_OP_STAT_WR)) begin
                    // Whole write refused, so the enable bit can't drop
                    if (wel_out && !hw_prot) begin
                        protect_pin_enable_bit_d = sh_q[`SFAC_ST_PROTECT_PIN_ENABLE_BIT];
                        bph_d  = sh_q[`SFAC_ST_BPH];
                        bpl_d  = sh_q[`SFAC_ST_BPL];
                        wel_d  = 1'b0;
                    end
                end else if (op_is(op_q, `SFAC_OP_SECT_ER)) begin
                    if (wel_out && !locked(addr_q[16:15], bp)) begin
                        busy_d  = 1'b1;
                        kind_d  = sfac_pkg::K_SECT;
                        walk_d  = {addr_q[16:15], `SFAC_SECT_FIRST};
                        wend_d  = {addr_q[16:15], `SFAC_SECT_LAST};
                        timer_d = SECT_CYCLES;
                        wdone_d = 1'b0;
                    end
                end else if (op_is(op_q, `SFAC_OP_CHIP_ER)) begin
                    if (wel_out && bp != `SFAC_BP_ALL) begin
                        busy_d  = 1'b1;
                        kind_d  = sfac_pkg::K_CHIP;
                        walk_d  = `SFAC_ADDR_ZERO;
                        wend_d  = `SFAC_ADDR_TOP;
                        timer_d = CHIP_CYCLES;
                        wdone_d = 1'b0;
                    end
                end
            end else if (cs_rise && state_q == sfac_pkg::ST_PGM) begin
                // Only a whole final byte arms the cycle
                if (wel_out && cnt_q == 5'h0 && |pmask_q
                    && !locked(addr_q[16:15], bp)) begin
                    busy_d  = 1'b1;
                    kind_d  = sfac_pkg::K_PGM;
                    walk_d  = {addr_q[16:8], `SFAC_PAGE_FIRST};
                    wend_d  = {addr_q[16:8], `SFAC_PAGE_LAST};
                    timer_d = PROG_CYCLES;
                    wdone_d = 1'b0;
                end
            end
        end else begin
            if (sck_rise) begin
                cnt_d = cnt_q + 5'h1;
                sh_d  = byte_in;
                case (state_q)
                    sfac_pkg::ST_CMD: begin
                        if (cnt_q[2:0] == `SFAC_BIT_LAST) begin
                            op_d  = byte_in;
                            cnt_d = 5'h0;
                            if (busy_out && !op_is(byte_in, `SFAC_OP_STAT_RD))
                                state_d = sfac_pkg::ST_SKIP;
                            else if (op_is(byte_in, `SFAC_OP_READ)
                                  || op_is(byte_in, `SFAC_OP_PROG)
                                  || op_is(byte_in, `SFAC_OP_SECT_ER))
                                state_d = sfac_pkg::ST_ADDR;
                            else if (op_is(byte_in, `SFAC_OP_STAT_RD))
                                state_d = sfac_pkg::ST_STAT;
                            else if (op_is(byte_in, `SFAC_OP_STAT_WR))
                                state_d = sfac_pkg::ST_WRSR;
                            else
                                state_d = sfac_pkg::ST_TAIL;
                        end
                    end
                    sfac_pkg::ST_ADDR: begin
                        addr_d = {addr_q[15:0], si_s_q};
                        if (cnt_q == `SFAC_ADDR_LAST) begin
                            cnt_d   = 5'h0;
                            pmask_d = '0;
                            if (op_is(op_q, `SFAC_OP_READ))
                                state_d = sfac_pkg::ST_RD;
                            else if (op_is(op_q, `SFAC_OP_PROG))
                                state_d = sfac_pkg::ST_PGM;
                            else
                                state_d = sfac_pkg::ST_TAIL;
                        end
                    end
                    sfac_pkg::ST_PGM: begin
                        if (cnt_q[2:0] == `SFAC_BIT_LAST) begin
                            cnt_d   = 5'h0;
                            pbuf_we = 1'b1;
                            pmask_d[addr_q[7:0]] = 1'b1;
                            addr_d[7:0] = addr_q[7:0] + 8'h1;
                        end
                    end
                    sfac_pkg::ST_RD, sfac_pkg::ST_STAT: begin
                        if (cnt_q[2:0] == `SFAC_BIT_LAST) begin
                            cnt_d = 5'h0;
                            if (state_q == sfac_pkg::ST_RD)
                                addr_d = addr_q + 17'h1;
                        end
                    end
                    sfac_pkg::ST_WRSR: begin
                        if (cnt_q[2:0] == `SFAC_BIT_LAST) begin
                            cnt_d   = 5'h0;
                            state_d = sfac_pkg::ST_TAIL;
                        end
                    end
                    sfac_pkg::ST_TAIL: begin
                        // Stray bits after a command void it
                        sh_d    = sh_q;
                        state_d = sfac_pkg::ST_SKIP;
                    end
                    default: cnt_d = 5'h0;
                endcase
            end
            if (sck_fall && (state_q == sfac_pkg::ST_RD
                          || state_q == sfac_pkg::ST_STAT)) begin
                oe_n_d = 1'b0;
                if (cnt_q[2:0] == `SFAC_BIT_FIRST) begin
                    out_d = (state_q == sfac_pkg::ST_RD) ? mem_rd_q
                          : stat_byte;
                    so_d  = out_d[7];
                end else begin
                    so_d  = out_q[6];
                    out_d = {out_q[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q     <= sfac_pkg::ST_CMD;
            kind_q      <= sfac_pkg::K_PGM;
            cnt_q       <= 5'h0;
            sh_q        <= 8'h00;
            op_q        <= 8'h00;
            out_q       <= 8'h00;
            addr_q      <= 17'h00000;
            walk_q      <= 17'h00000;
            wend_q      <= 17'h00000;
            timer_q     <= 32'h0;
            pmask_q     <= '0;
            wdone_q     <= 1'b1;
            so_out      <= 1'b0;
            so_oe_n_out <= 1'b1;
            busy_out    <= 1'b0;
            wel_out     <= 1'b0;
            block_protect_low_out      <= 1'b0;
            block_protect_high_out     <= 1'b0;
            protect_pin_enable_bit_out <= 1'b0;
        end else begin
            state_q     <= state_d;
            kind_q      <= kind_d;
            cnt_q       <= cnt_d;
            sh_q        <= sh_d;
            op_q        <= op_d;
            out_q       <= out_d;
            addr_q      <= addr_d;
            walk_q      <= walk_d;
            wend_q      <= wend_d;
            timer_q     <= timer_d;
            pmask_q     <= pmask_d;
            wdone_q     <= wdone_d;
            so_out      <= so_d;
            so_oe_n_out <= oe_n_d;
            busy_out    <= busy_d;
            wel_out     <= wel_d;
            block_protect_low_out      <= bpl_d;
            block_protect_high_out     <= bph_d;
            protect_pin_enable_bit_out <= protect_pin_enable_bit_d;
        end
    end

    // Array walk writes one byte per clock; locked sectors are skipped
    assign mem_we = busy_out && !wdone_q
                 && (kind_q == sfac_pkg::K_PGM ? pmask_q[walk_q[7:0]]
                     : !locked(walk_q[16:15], bp));
    assign mem_wdata = (kind_q == sfac_pkg::K_PGM) ? pbuf[walk_q[7:0]]
                     : `SFAC_ERASED;

    initial begin
        for (int i = 0; i < `SFAC_MEM_BYTES; i++)
            mem[i] = `SFAC_ERASED;
    end

    always_ff @(posedge clk_in) begin
        if (mem_we)
            mem[walk_q] <= mem_wdata;
        mem_rd_q <= mem[addr_q];
        if (pbuf_we)
            pbuf[addr_q[7:0]] <= byte_in;
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_stat_busy_bit: assert property (
        sck_fall && state_q == sfac_pkg::ST_STAT && busy_out
        && cnt_q[2:0] == `SFAC_BIT_FIRST |=> so_out && !so_oe_n_out)
        else $error("status MSB not one while busy");
    a_wel_auto_clear: assert property (
        $fell(busy_out) |-> !wel_out)
        else $error("write latch still set after cycle");
    a_busy_ignore_cmd: assert property (
        busy_out && !cs_s_q && sck_rise && state_q == sfac_pkg::ST_CMD
        && cnt_q[2:0] == `SFAC_BIT_LAST
        && !op_is(byte_in, `SFAC_OP_STAT_RD) |=> state_q == sfac_pkg::ST_SKIP)
        else $error("command accepted while busy");
    a_read_wrap_top: assert property (
        !cs_s_q && sck_rise && state_q == sfac_pkg::ST_RD
        && cnt_q[2:0] == `SFAC_BIT_LAST && addr_q == `SFAC_ADDR_TOP
        |=> addr_q == `SFAC_ADDR_ZERO)
        else $error("read address did not wrap");
    a_read_addr_incr: assert property (
        !cs_s_q && sck_rise && state_q == sfac_pkg::ST_RD
        && cnt_q[2:0] == `SFAC_BIT_LAST |=> addr_q == $past(addr_q) + 17'h1)
        else $error("read address not incremented");
    a_no_wel_start: assert property (
        cs_rise && !wel_out && !busy_out |=> !busy_out)
        else $error("write started without latch");
    a_protect_pin_enable_bit_hold: assert property (
        !wp_s_q && protect_pin_enable_bit_out |=> protect_pin_enable_bit_out)
        else $error("enable bit cleared under protection");
    a_start_on_cs: assert property (
        $rose(busy_out) |-> $past(cs_rise))
        else $error("cycle started without chip select rise");
    a_chip_busy_hold: assert property (
        $rose(busy_out) && kind_q == sfac_pkg::K_CHIP |-> busy_out[*8])
        else $error("chip erase ended too early");
    a_locked_no_start: assert property (
        cs_rise && state_q == sfac_pkg::ST_TAIL
        && op_is(op_q, `SFAC_OP_SECT_ER) && locked(addr_q[16:15], bp)
        |=> !busy_out)
        else $error("locked sector erase started");
endmodule

// *** verilog/sfac_pkg.sv ***
package sfac_pkg;
    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_RD, ST_STAT, ST_PGM, ST_WRSR, ST_TAIL, ST_SKIP
    } sfac_state_e;

    typedef enum logic [1:0] {
        K_PGM, K_SECT, K_CHIP
    } sfac_kind_e;
endpackage
